// ---- uhirq_cfg.svh ----
// Register offsets, field positions and reset values of the interrupt block
`ifndef UHIRQ_CFG_SVH
`define UHIRQ_CFG_SVH

// ==========================================================
// Register map (byte addresses)
`define UHIRQ_ADDR_W 32
`define UHIRQ_OFS_STATUS 32'h30002c0c
`define UHIRQ_OFS_EN_SET 32'h30002c10
`define UHIRQ_OFS_EN_CLR 32'h30002c14
`define UHIRQ_OFS_COMM_BASE 32'h30002c18

// ==========================================================
// Field positions
`define UHIRQ_BIT_MASTER 31
`define UHIRQ_BIT_OWN_CHG 30
`define UHIRQ_BIT_RH_CHG 6
`define UHIRQ_BIT_FN_OVF 5
`define UHIRQ_BIT_UNREC 4
`define UHIRQ_BIT_RESUME 3
`define UHIRQ_BIT_SOF 2
`define UHIRQ_BIT_DONE_WB 1
`define UHIRQ_BIT_SCHED_OVR 0

// ==========================================================
// Masks and reset values
`define UHIRQ_EVENT_MASK 32'h4000007f
`define UHIRQ_ENABLE_MASK 32'hc000007f
`define UHIRQ_BASE_MASK 32'hffffff00
`define UHIRQ_EN_RESET 32'h00000000
`define UHIRQ_STATUS_RESET 32'h00000000
`define UHIRQ_BASE_RESET 32'h00000000
`define UHIRQ_REG_COUNT 4

`endif

// ---- uhirq_pkg.sv ----
// Types shared by the interrupt enable block
package uhirq_pkg;
  typedef logic [31:0] uhirq_word_t;
  typedef logic [1:0] uhirq_idx_t;
endpackage : uhirq_pkg

// ---- uhirq_regmem.sv ----
// Small register store: four words, registered read port
`timescale 1ns/1ps
`include "uhirq_cfg.svh"
module uhirq_regmem (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Per-word write enable, with the full new value of each word
  input wire logic [`UHIRQ_REG_COUNT-1:0] wr_en,
  input wire uhirq_pkg::uhirq_word_t wr_data [`UHIRQ_REG_COUNT],
  // Registered read
  input wire uhirq_pkg::uhirq_idx_t rd_idx,
  output uhirq_pkg::uhirq_word_t rd_data,
  output uhirq_pkg::uhirq_word_t words [`UHIRQ_REG_COUNT]
);
  import uhirq_pkg::*;

  // ==========================================================
  // Storage
  uhirq_word_t mem_q [`UHIRQ_REG_COUNT];
  uhirq_word_t mem_d [`UHIRQ_REG_COUNT];
  uhirq_word_t rd_q;
  uhirq_word_t rd_d;

  genvar g;
  generate
    for (g = 0; g < `UHIRQ_REG_COUNT; g++) begin : g_word
      always_comb begin
        mem_d[g] = wr_en[g] ? wr_data[g] : mem_q[g];
      end
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          mem_q[g] <= 32'h00000000;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
      assign words[g] = mem_q[g];
    end
  endgenerate

  always_comb begin
    rd_d = mem_q[rd_idx];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 32'h00000000;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
endmodule : uhirq_regmem

// ---- uhirq_ctrl.sv ----
// Interrupt enable, status and communication-area base of the USB host
`timescale 1ns/1ps
`include "uhirq_cfg.svh"
module uhirq_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Software reset from the controller core
  input wire logic soft_reset,
  // Register port
  input wire uhirq_pkg::uhirq_word_t reg_addr,
  input wire uhirq_pkg::uhirq_word_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output uhirq_pkg::uhirq_word_t reg_rdata,
  // Event pulses from the core, in status bit layout
  input wire uhirq_pkg::uhirq_word_t event_pulse,
  // Core-side views
  output uhirq_pkg::uhirq_word_t comm_area_base,
  output uhirq_pkg::uhirq_word_t event_status_flags,
  // Host interrupt
  output logic irq
);
  import uhirq_pkg::*;

  // ==========================================================
  // Address decode
  uhirq_idx_t idx;
  logic hit;
  always_comb begin
    hit = 1'b1;
    idx = 2'h0;
    unique case (reg_addr)
      `UHIRQ_OFS_STATUS: idx = 2'h0;
      `UHIRQ_OFS_EN_SET: idx = 2'h1;
      `UHIRQ_OFS_EN_CLR: idx = 2'h2;
      `UHIRQ_OFS_COMM_BASE: idx = 2'h3;
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Next values of the stored words
  uhirq_word_t words [`UHIRQ_REG_COUNT];
  uhirq_word_t wr_data [`UHIRQ_REG_COUNT];
  logic [`UHIRQ_REG_COUNT-1:0] wr_en;
  uhirq_word_t status_now;
  uhirq_word_t enable_now;
  uhirq_idx_t rd_sel;
  uhirq_word_t rdata_q;
  uhirq_word_t rdata_d;
  logic miss_d;
  logic irq_q;
  logic irq_d;
  logic wr_status;
  logic wr_set;
  logic wr_clr;
  logic wr_base;

  // Word 1 holds enables; word 2 is unused since the clear view aliases it
  assign status_now = words[0];
  assign enable_now = words[1];

  always_comb begin
    wr_status = reg_write && hit && idx == 2'h0;
    wr_set = reg_write && hit && idx == 2'h1;
    wr_clr = reg_write && hit && idx == 2'h2;
    wr_base = reg_write && hit && idx == 2'h3;
    wr_en = '0;
    wr_data[0] = status_now;
    wr_data[1] = enable_now;
    wr_data[2] = 32'h00000000;
    wr_data[3] = words[3];
    // Set wins over a same-cycle write-one clear
    wr_data[0] = (status_now & ~(wr_status ? reg_wdata : 32'h00000000))
      | (event_pulse & `UHIRQ_EVENT_MASK);
    wr_en[0] = 1'b1;
    if (soft_reset) begin
      wr_data[0] = `UHIRQ_STATUS_RESET;
    end
    if (wr_set) begin
      wr_data[1] = enable_now | (reg_wdata & `UHIRQ_ENABLE_MASK);
      wr_en[1] = 1'b1;
    end else if (wr_clr) begin
      wr_data[1] = enable_now & ~(reg_wdata & `UHIRQ_ENABLE_MASK);
      wr_en[1] = 1'b1;
    end
    if (soft_reset) begin
      wr_data[1] = `UHIRQ_EN_RESET;
      wr_en[1] = 1'b1;
    end
    if (wr_base) begin
      wr_data[3] = reg_wdata & `UHIRQ_BASE_MASK;
      wr_en[3] = 1'b1;
    end
  end

  uhirq_regmem u_mem (
    .clock(clock),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_idx(rd_sel),
    .rd_data(),
    .words(words)
  );

  // ==========================================================
  // Read answer: unmapped reads return zero; the clear view aliases enables
  assign rd_sel = (idx == 2'h2) ? 2'h1 : idx;

  // Mux before the flop so the read data pin comes straight from a register
  always_comb begin
    miss_d = !(reg_read && hit);
    rdata_d = miss_d ? 32'h00000000 : words[rd_sel];
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Interrupt request, registered so the pin comes from a flop
  always_comb begin
    irq_d = enable_now[`UHIRQ_BIT_MASTER]
      && |(status_now & enable_now & `UHIRQ_EVENT_MASK);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;
  assign comm_area_base = words[3];
  assign event_status_flags = status_now;
endmodule : uhirq_ctrl

// ---- uhirq_ctrl_assertions.sv ----
// Port checks of the interrupt enable block
`timescale 1ns/1ps
`include "uhirq_cfg.svh"
module uhirq_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Watched ports
  input wire logic soft_reset,
  input wire uhirq_pkg::uhirq_word_t reg_addr,
  input wire uhirq_pkg::uhirq_word_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire uhirq_pkg::uhirq_word_t reg_rdata,
  input wire uhirq_pkg::uhirq_word_t event_pulse,
  input wire uhirq_pkg::uhirq_word_t comm_area_base,
  input wire uhirq_pkg::uhirq_word_t event_status_flags,
  input wire logic irq
);
  import uhirq_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic ws;
  assign ws = reg_write && reg_addr == `UHIRQ_OFS_STATUS;
  base_low_a: assert property (comm_area_base[7:0] == 8'h00)
    else $error("base low byte set");
  base_wr_a: assert property (reg_write && !soft_reset &&
    reg_addr == `UHIRQ_OFS_COMM_BASE |=> comm_area_base ==
    ($past(reg_wdata) & `UHIRQ_BASE_MASK)) else $error("base write");
  base_rd_a: assert property (reg_read &&
    reg_addr == `UHIRQ_OFS_COMM_BASE |=> reg_rdata ==
    $past(comm_area_base)) else $error("base read");
  en_rsv_a: assert property (reg_read && (reg_addr == `UHIRQ_OFS_EN_SET
    || reg_addr == `UHIRQ_OFS_EN_CLR) |=> (reg_rdata & ~`UHIRQ_ENABLE_MASK)
    == '0) else $error("reserved enable bit");
  ev_set_a: assert property (!soft_reset |=> (($past(event_pulse) &
    `UHIRQ_EVENT_MASK) & ~event_status_flags) == '0) else $error("event");
  st_hold_a: assert property (!ws && !soft_reset |=>
    ($past(event_status_flags) & ~event_status_flags) == '0)
    else $error("status lost");
  st_clr_a: assert property (ws && !soft_reset && event_pulse == '0 |=>
    event_status_flags == ($past(event_status_flags) & ~$past(reg_wdata)))
    else $error("status clear");
  irq_cause_a: assert property (irq |-> $past(event_status_flags) != '0)
    else $error("irq without status");
endmodule : uhirq_chk
bind uhirq_ctrl uhirq_chk chk (.clock, .rst_b, .soft_reset, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .event_pulse,
  .comm_area_base, .event_status_flags, .irq);

// ---- uhirq_irq_sink.sv ----
// Processor interrupt input model
`timescale 1ns/1ps
module uhirq_irq_sink (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Level request in, taken level out
  input wire logic irq,
  output logic irq_taken
);
  // Registered like a real input stage, so one cycle late
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_taken <= 1'b0;
    end else begin
      irq_taken <= irq;
    end
  end
endmodule : uhirq_irq_sink

// ---- uhirq_ctrl_tb.sv ----
// Self-checking bench of the interrupt enable block
`timescale 1ns/1ps
`include "uhirq_cfg.svh"
module uhirq_ctrl_tb;
  import uhirq_pkg::*;
  logic clock = 0, rst_b = 0, soft_reset = 0, reg_write = 0, reg_read = 0;
  uhirq_word_t reg_addr = '0, reg_wdata = '0, event_pulse = '0;
  uhirq_word_t reg_rdata, comm_area_base, event_status_flags;
  logic irq, irq_taken;
  int failures = 0, n_tests = 0, b;
  always #4 clock = ~clock;
  uhirq_ctrl dut (.clock, .rst_b, .soft_reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .event_pulse, .comm_area_base,
    .event_status_flags, .irq);
  uhirq_irq_sink cpu (.clock, .rst_b, .irq, .irq_taken);
  task automatic chk(input uhirq_word_t got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input uhirq_word_t a, d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr
  // Data stand one cycle only, so look mid-cycle
  task automatic rd(input uhirq_word_t a, exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp);
    @(posedge clock);
  endtask : rd
  // Enable, irq and sink each add one cycle
  task automatic ck_irq(input uhirq_word_t exp);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk({31'h0, irq_taken}, exp);
    @(posedge clock);
  endtask : ck_irq
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #20us;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(`UHIRQ_OFS_EN_SET, 32'h0);
    wr(`UHIRQ_OFS_COMM_BASE, 32'hffffffff);
    rd(`UHIRQ_OFS_COMM_BASE, 32'hffffff00);
    chk(comm_area_base, 32'hffffff00);
    for (int i = 0; i < 8; i++) begin
      b = (i == 7) ? 30 : i;
      wr(`UHIRQ_OFS_EN_SET, 32'h1 << b);
      event_pulse <= 32'h1 << b;
      @(posedge clock);
      event_pulse <= '0;
      ck_irq(32'h0);
      wr(`UHIRQ_OFS_EN_SET, 32'h80000000);
      ck_irq(32'h1);
      wr(`UHIRQ_OFS_EN_CLR, ~(32'h80000000 | 32'h1 << b));
      ck_irq(32'h1);
      rd(`UHIRQ_OFS_EN_CLR, 32'h80000000 | 32'h1 << b);
      wr(`UHIRQ_OFS_EN_CLR, 32'h1 << b);
      ck_irq(32'h0);
      wr(`UHIRQ_OFS_EN_SET, 32'h1 << b);
      ck_irq(32'h1);
      wr(`UHIRQ_OFS_EN_CLR, 32'h80000000);
      ck_irq(32'h0);
      wr(`UHIRQ_OFS_STATUS, 32'h1 << b);
      rd(`UHIRQ_OFS_STATUS, 32'h0);
    end
    wr(`UHIRQ_OFS_EN_SET, 32'h7fffffff);
    rd(`UHIRQ_OFS_EN_SET, 32'h4000007f);
    rd(32'h30002c40, 32'h0);
    wr(`UHIRQ_OFS_EN_SET, 32'h80000001);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    rd(`UHIRQ_OFS_EN_CLR, 32'h0);
    end_of_test();
  end
endmodule : uhirq_ctrl_tb
